// ==== core/startup_config_consts.vh ====
`ifndef STARTUP_CONFIG_CONSTS_VH
`define STARTUP_CONFIG_CONSTS_VH

// Register indices; byte address is four times the index
`define CFG_IDX_STARTUP 16'h103F
`define CFG_IDX_NV_CTRL 16'h1040
`define CFG_ADDR_STARTUP 16'h40FC
`define CFG_ADDR_NV_CTRL 16'h4100

// Field positions inside startup_configuration
`define CFG_BIT_SECURITY_DISABLE 3
`define CFG_BIT_WATCHDOG_DISABLE 2
`define CFG_BIT_INTERNAL_ROM_ENABLE 1
`define CFG_BIT_EEPROM_ENABLE 0

// Field positions inside the programming control register
`define CFG_BIT_PROG_ENABLE 0
`define CFG_BIT_PROG_ERASE 1

// Reset and erased values
`define CFG_NV_ERASED 4'hF
`define CFG_NV_CTRL_RESET 2'h0

// Operating modes from the two mode-select pins
`define CFG_MODE_BOOTSTRAP 2'h0
`define CFG_MODE_TEST 2'h1
`define CFG_MODE_SINGLE_CHIP 2'h2
`define CFG_MODE_EXPANDED 2'h3

// AXI responses
`define CFG_RESP_OKAY 2'h0
`define CFG_RESP_SLVERR 2'h2

`endif

// ==== core/config_nv_cell.v ====
`include "startup_config_consts.vh"

module config_nv_cell #(
  parameter WIDTH = 4
) (
  input wire aclk, // System clock
  input wire por_n, // Power-on reset, active low
  input wire prog_strobe, // One-cycle program or erase access
  input wire erase, // Erase instead of program
  input wire [WIDTH-1:0] wdata, // Data to program
  output reg [WIDTH-1:0] stored_reg // Nonvolatile contents
);

  // Chip reset does not touch this cell; only power-on or an erase access gives it the erased state.
  // Programming can only clear bits, erase returns them to one.
  always @(posedge aclk) begin
    if (!por_n) begin
      stored_reg <= `CFG_NV_ERASED;
    end else if (prog_strobe) begin
      if (erase) begin
        stored_reg <= `CFG_NV_ERASED;
      end else begin
        stored_reg <= stored_reg & wdata;
      end
    end
  end

endmodule

// ==== core/startup_config_shadow_latches.v ====
// Local design decision: the AXI4-Lite register port.
`include "startup_config_consts.vh"

module startup_config_shadow_latches #(
  parameter ADDR_WIDTH = 16,
  parameter SECURITY_OPTION = 1
) (
  input wire aclk, // System clock
  input wire aresetn, // Chip reset sequence, active low
  input wire por_n, // Power-on reset for the nonvolatile cell, active low
  input wire [1:0] mode_select, // Mode-select pins
  input wire disable_resets_test, // Disable-resets bit of factory test register one
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [ADDR_WIDTH-1:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  output reg security_enabled, // Security active
  output reg watchdog_enable, // Watchdog system enabled
  output reg internal_rom_enable, // Internal ROM in memory map
  output reg eeprom_enable, // Internal EEPROM in memory map
  output reg [1:0] operating_mode // Mode captured at reset
);

  reg [1:0] mode_meta_reg;
  reg [1:0] mode_sync_reg;
  reg [1:0] mode_reg;
  reg [3:0] latch_reg;
  reg [1:0] nv_ctrl_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [ADDR_WIDTH-1:0] awaddr_reg;
  reg [7:0] wbyte_reg;
  reg wstrb0_reg;
  wire [3:0] stored;
  wire [7:0] read_config;
  wire write_go;
  wire [ADDR_WIDTH-1:0] wr_addr;
  wire [7:0] wr_byte;
  wire wr_lane;
  wire prog_strobe;
  wire boot_or_test;
  wire reset_boot_or_test;
  reg sec_bit;

  // Mode pins come from outside and pass two flops before use
  always @(posedge aclk) begin
    mode_meta_reg <= mode_select;
    mode_sync_reg <= mode_meta_reg;
  end

  assign reset_boot_or_test = (mode_sync_reg == `CFG_MODE_BOOTSTRAP) ||
                              (mode_sync_reg == `CFG_MODE_TEST);
  assign boot_or_test = (mode_reg == `CFG_MODE_BOOTSTRAP) || (mode_reg == `CFG_MODE_TEST);

  // Write channel: address and data are taken in either order
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_byte = w_held_reg ? wbyte_reg : s_axi_wdata[7:0];
  assign wr_lane = w_held_reg ? wstrb0_reg : s_axi_wstrb[0];
  assign write_go = !s_axi_bvalid && (aw_held_reg || s_axi_awvalid) &&
                    (w_held_reg || s_axi_wvalid);
  // Ordinary writes leave the cell alone; only an enabled programming access reaches it
  assign prog_strobe = write_go && wr_lane && (wr_addr == `CFG_ADDR_STARTUP) &&
                       nv_ctrl_reg[`CFG_BIT_PROG_ENABLE];

  config_nv_cell #(
    .WIDTH(4)
  ) u_cell (
    .aclk(aclk),
    .por_n(por_n),
    .prog_strobe(prog_strobe),
    .erase(nv_ctrl_reg[`CFG_BIT_PROG_ERASE]),
    .wdata(wr_byte[3:0]),
    .stored_reg(stored)
  );

  always @* begin
    sec_bit = latch_reg[`CFG_BIT_SECURITY_DISABLE];
    if (SECURITY_OPTION == 0) begin
      sec_bit = 1'b1;
    end
  end

  // Reads see the latches, never the cell; upper nibble is unimplemented
  assign read_config = {4'h0, sec_bit, latch_reg[2:0]};

  // Working latches: reloaded throughout reset, watchdog-disable only outside bootstrap and test; frozen afterwards
  always @(posedge aclk) begin
    if (!por_n) begin
      latch_reg <= `CFG_NV_ERASED;
      mode_reg <= `CFG_MODE_SINGLE_CHIP;
    end else if (!aresetn) begin
      mode_reg <= mode_sync_reg;
      latch_reg[`CFG_BIT_EEPROM_ENABLE] <= stored[`CFG_BIT_EEPROM_ENABLE];
      if (mode_sync_reg == `CFG_MODE_SINGLE_CHIP) begin
        latch_reg[`CFG_BIT_INTERNAL_ROM_ENABLE] <= 1'b1;
      end else begin
        latch_reg[`CFG_BIT_INTERNAL_ROM_ENABLE] <= stored[`CFG_BIT_INTERNAL_ROM_ENABLE];
      end
      if ((mode_sync_reg == `CFG_MODE_EXPANDED) || (mode_sync_reg == `CFG_MODE_TEST)) begin
        latch_reg[`CFG_BIT_SECURITY_DISABLE] <= 1'b1;
      end else begin
        latch_reg[`CFG_BIT_SECURITY_DISABLE] <= stored[`CFG_BIT_SECURITY_DISABLE];
      end
      // Bootstrap and test keep the old watchdog-disable level across reset
      if (!reset_boot_or_test) begin
        latch_reg[`CFG_BIT_WATCHDOG_DISABLE] <= stored[`CFG_BIT_WATCHDOG_DISABLE];
      end
    end
  end

  // Chip options come from the latches, except watchdog_enable in bootstrap and test, which follows disable_resets_test; registered for clean outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      security_enabled <= 1'b0;
      watchdog_enable <= 1'b0;
      internal_rom_enable <= 1'b0;
      eeprom_enable <= 1'b0;
      operating_mode <= `CFG_MODE_SINGLE_CHIP;
    end else begin
      security_enabled <= !sec_bit;
      if (boot_or_test) begin
        watchdog_enable <= !disable_resets_test;
      end else begin
        watchdog_enable <= !latch_reg[`CFG_BIT_WATCHDOG_DISABLE];
      end
      internal_rom_enable <= latch_reg[`CFG_BIT_INTERNAL_ROM_ENABLE] ||
                             (mode_reg == `CFG_MODE_SINGLE_CHIP);
      eeprom_enable <= latch_reg[`CFG_BIT_EEPROM_ENABLE];
      operating_mode <= mode_reg;
    end
  end

  // Write side of the register slave
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= {ADDR_WIDTH{1'b0}};
      wbyte_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CFG_RESP_OKAY;
      nv_ctrl_reg <= `CFG_NV_CTRL_RESET;
    end else begin
      if (write_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_addr == `CFG_ADDR_STARTUP) begin
          s_axi_bresp <= `CFG_RESP_OKAY;
        end else if (wr_addr == `CFG_ADDR_NV_CTRL) begin
          s_axi_bresp <= `CFG_RESP_OKAY;
          if (wr_lane) begin
            nv_ctrl_reg <= wr_byte[1:0];
          end
        end else begin
          s_axi_bresp <= `CFG_RESP_SLVERR;
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          awaddr_reg <= s_axi_awaddr;
          s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          wbyte_reg <= s_axi_wdata[7:0];
          wstrb0_reg <= s_axi_wstrb[0];
          s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
          s_axi_awready <= 1'b1;
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  // Read side: one read in flight, data one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CFG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == `CFG_ADDR_STARTUP) begin
        s_axi_rdata <= {24'h000000, read_config};
        s_axi_rresp <= `CFG_RESP_OKAY;
      end else if (s_axi_araddr == `CFG_ADDR_NV_CTRL) begin
        s_axi_rdata <= {30'h00000000, nv_ctrl_reg};
        s_axi_rresp <= `CFG_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `CFG_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== verification/reset_sequencer.sv ====
module reset_sequencer #(
  parameter int LOW = 4
) (
  input wire logic aclk, // clock
  input wire logic restart, // request a chip reset
  output logic aresetn, // chip reset sequence
  output logic por_n // power-on reset
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 21;
  logic chip_n_reg = 1'b0;
  logic power_n_reg = 1'b0;
  assign aresetn = chip_n_reg;
  assign por_n = power_n_reg;
  // Chip reset outlasts power-on reset so the synced mode pins settle
  always @(posedge aclk) begin
    if (restart)
      cnt <= LOW;
    else if (cnt > 0)
      cnt <= cnt - 1;
    chip_n_reg <= !restart && (cnt <= 1);
    power_n_reg <= power_n_reg | (cnt < 10);
  end
endmodule

// ==== verification/config_monitor.sv ====
`include "startup_config_consts.vh"
module config_monitor (
  input wire aclk, // clock
  input wire aresetn, // reset
  input wire disable_resets_test, // test bit
  input wire [15:0] s_axi_araddr, // ar
  input wire s_axi_arvalid, // ar
  input wire s_axi_arready, // ar
  input wire [31:0] s_axi_rdata, // r
  input wire [1:0] s_axi_rresp, // r
  input wire s_axi_rvalid, // r
  input wire s_axi_rready, // r
  input wire [1:0] s_axi_bresp, // b
  input wire s_axi_bvalid, // b
  input wire s_axi_bready, // b
  input wire security_enabled, // option
  input wire watchdog_enable, // option
  input wire internal_rom_enable, // option
  input wire eeprom_enable, // option
  input wire [1:0] operating_mode // mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_read_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_unmapped_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr != `CFG_ADDR_STARTUP
    && s_axi_araddr != `CFG_ADDR_NV_CTRL |=> s_axi_rresp == `CFG_RESP_SLVERR
    && s_axi_rdata == 32'h00000000)
    else $error("unmapped read accepted");
  chk_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0000000)
    else $error("upper bits not zero");
  chk_rom_single: assert property (
    $past(aresetn) && operating_mode == `CFG_MODE_SINGLE_CHIP |-> internal_rom_enable)
    else $error("rom not forced in single chip");
  chk_sec_forced: assert property (
    $past(aresetn) && operating_mode[0] |-> !security_enabled)
    else $error("security not disabled");
  chk_wd_test: assert property (
    $past(aresetn) && !operating_mode[1] |-> watchdog_enable == !$past(disable_resets_test))
    else $error("watchdog ignores test bit");
  chk_options_stable: assert property (
    $past(aresetn) && $past(aresetn, 2)
    |-> $stable({security_enabled, internal_rom_enable, eeprom_enable}))
    else $error("options moved without reset");
endmodule
bind startup_config_shadow_latches config_monitor mon (.*);

// ==== verification/tb_top.sv ====
`include "startup_config_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, restart = 1'b0, aresetn, por_n, disable_resets_test = 1'b0;
  logic [1:0] mode_select = `CFG_MODE_SINGLE_CHIP;
  logic [15:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, prev;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic security_enabled, watchdog_enable, internal_rom_enable, eeprom_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, operating_mode, rs;
  int failures = 0, tests_run = 0, cycles = 0;
  logic [3:0] opts;
  assign opts = {security_enabled, watchdog_enable, internal_rom_enable, eeprom_enable};
  // Nibbles: control, config write, reset mode, read back, option outputs
  logic [19:0] rows [7] = '{20'h123A6, 20'h0022E, 20'h10384, 20'h0F00C,
                            20'h300B7, 20'h001B7, 20'h002F3};
  always #2 aclk = ~aclk;
  startup_config_shadow_latches uut (.*);
  reset_sequencer seq (.aclk(aclk), .restart(restart), .aresetn(aresetn), .por_n(por_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(`CFG_RESP_OKAY));
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask
  // Mode pins are set well ahead so both sync stages see them during reset
  task automatic rst(input logic [1:0] m);
    mode_select <= m;
    repeat (3) @(posedge aclk);
    restart <= 1'b1;
    @(posedge aclk);
    restart <= 1'b0;
    do @(posedge aclk); while (aresetn !== 1'b1);
    repeat (3) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    do @(posedge aclk); while (aresetn !== 1'b1);
    repeat (3) @(posedge aclk);
    prev = 4'hF;
    rd_reg(`CFG_ADDR_STARTUP, rd, rs);
    chk(rd, 32'h0000000F);
    chk(32'(opts), 32'h3);
    foreach (rows[i]) begin
      wr(`CFG_ADDR_NV_CTRL, 32'(rows[i][19:16]));
      wr(`CFG_ADDR_STARTUP, 32'(rows[i][15:12]));
      rd_reg(`CFG_ADDR_STARTUP, rd, rs);
      chk(rd, 32'(prev));
      rst(rows[i][9:8]);
      rd_reg(`CFG_ADDR_STARTUP, rd, rs);
      chk(rd, 32'(rows[i][7:4]));
      chk(32'(rs), 32'(`CFG_RESP_OKAY));
      chk(32'(opts), 32'(rows[i][3:0]));
      chk(32'(operating_mode), 32'(rows[i][9:8]));
      prev = rows[i][7:4];
    end
    rst(`CFG_MODE_TEST);
    chk(32'(watchdog_enable), 32'h1);
    disable_resets_test <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(watchdog_enable), 32'h0);
    disable_resets_test <= 1'b0;
    rd_reg(16'h0000, rd, rs);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(`CFG_RESP_SLVERR));
    // A programming write with lane 0 masked must leave the cell alone
    rst(`CFG_MODE_SINGLE_CHIP);
    wr(`CFG_ADDR_NV_CTRL, 32'h00000001);
    rd_reg(`CFG_ADDR_NV_CTRL, rd, rs);
    chk(rd, 32'h00000001);
    s_axi_wstrb <= 4'hE;
    wr(`CFG_ADDR_STARTUP, 32'h00000000);
    s_axi_wstrb <= 4'hF;
    rst(`CFG_MODE_SINGLE_CHIP);
    rd_reg(`CFG_ADDR_STARTUP, rd, rs);
    chk(rd, 32'h0000000F);
    stop_test();
  end
endmodule
